// ---- bench/btns_bus_model.sv ----
// partner model: the traced microcontroller bus, one bus cycle per call of cycle()
// assumes the bench clock; every bus line changes just after a rising edge
`timescale 1ns/1ps
module btns_bus_model (
    input  logic        clk_i,
    output logic [15:0] bus_addr_o,
    output logic [7:0]  bus_data_o,
    output logic        bus_read_o,
    output logic        fetch_o,
    output logic        bus_e_o,
    output logic [5:0]  tp_o
);
    initial begin
        bus_addr_o = 16'h0000;
        bus_data_o = 8'h00;
        bus_read_o = 1'b1;
        fetch_o    = 1'b0;
        bus_e_o    = 1'b0;
        tp_o       = 6'h00;
    end

    // phase high for two clocks, low for at least three (two here plus the entry edge); stale data inverted so it never passes for fresh
    task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic rd, input logic f,
                         input logic [5:0] tp);
        @(posedge clk_i);
        bus_addr_o <= a;
        bus_data_o <= d;
        bus_read_o <= rd;
        fetch_o    <= f;
        tp_o       <= tp;
        bus_e_o    <= 1'b1;
        repeat (2) @(posedge clk_i);
        bus_e_o    <= 1'b0;
        bus_data_o <= ~d;
        repeat (2) @(posedge clk_i);
    endtask : cycle
endmodule : btns_bus_model

// ---- bench/test_btns_sequencer.sv ----
// testbench of the trace sequencer: wishbone master tasks, one task per scenario
// assumes btns_bus_model plays the traced bus; init clear count shortened to 20
`timescale 1ns/1ps
`include "btns_regs.svh"
module test_btns_sequencer;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic        bus_read, fetch, bus_e;
    logic [15:0] bus_addr;
    logic [7:0]  bus_data, wb_adr_i;
    logic [5:0]  tp;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    int          num_errors, num_checks;

    btns_bus_model i_btns_bus_model (.clk_i(clk_i), .bus_addr_o(bus_addr), .bus_data_o(bus_data),
        .bus_read_o(bus_read), .fetch_o(fetch), .bus_e_o(bus_e), .tp_o(tp));

    btns_sequencer #(.AW(13), .INIT_CLEAR_CYCLES(20)) i_btns_sequencer (.clk_i(clk_i), .rst_i(rst_i),
        .bus_addr_i(bus_addr), .bus_data_i(bus_data), .bus_read_i(bus_read), .opcode_fetch_cycle_i(fetch),
        .bus_e_i(bus_e), .test_point_i(tp), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .nonmaskable_monitor_irq_o(irq));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held until ack is sampled; the entry edge keeps cyc low one cycle between transfers
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk("ack latency", 32'd2, n);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, adr, d, q);
    endtask : wr

    task automatic rc(input string what, input logic [7:0] adr, input logic [31:0] exp,
                      input logic [31:0] mask = 32'hffff_ffff);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0, q);
        chk(what, exp, q & mask);
    endtask : rc

    task automatic st_chk(input logic [4:0] exp);
        rc("state", `BTNS_OFS_STATE, {27'h0, exp});
    endtask : st_chk

    task automatic t_reset;
        logic [31:0] q;
        st_chk(`BTNS_ST_INIT);
        rc("init done early", `BTNS_OFS_STATUS, 32'h0, 32'h0800_0000);
        rc("unmapped", 8'hfc, 32'h0);
        repeat (25) @(posedge clk_i);
        rc("init done", `BTNS_OFS_STATUS, 32'h0800_0000, 32'h0800_0000);
        // flagged: 0xf000 (upper, via mirror) and 0x0100; all other used places loaded zero
        wr(`BTNS_OFS_TRIG_LOAD, 32'h3000_0001);
        wr(`BTNS_OFS_TRIG_LOAD, 32'h2000_0000);
        wr(`BTNS_OFS_TRIG_LOAD, 32'h0100_0001);
        wr(`BTNS_OFS_TRIG_LOAD, 32'h0200_0000);
        // a fetch seen in init must still store a cleared mark
        i_btns_bus_model.cycle(16'he000, 8'h77, 1'b1, 1'b1, 6'h00);
        rc("init counter", `BTNS_OFS_STATUS, 32'h1, 32'h1fff);
        wb(1'b0, `BTNS_OFS_DOWN, 32'h0, q);
        rc("init mark", `BTNS_OFS_STATUS, 32'h0, 32'h0400_1fff);
    endtask : t_reset

    task automatic t_exec;
        wr(`BTNS_OFS_PT_CLEAR, 32'h5a);
        wr(`BTNS_OFS_PT_PRESET, 32'd8190);
        wr(`BTNS_OFS_STATE, {27'h0, `BTNS_ST_EXE_WAIT});
        i_btns_bus_model.cycle(16'he000, 8'h86, 1'b1, 1'b1, 6'h15);
        st_chk(`BTNS_ST_EXE_CAP);
        rc("counter", `BTNS_OFS_STATUS, 32'h1, 32'h1fff);
        i_btns_bus_model.cycle(16'hf000, 8'h3c, 1'b1, 1'b0, 6'h2a);
        st_chk(`BTNS_ST_EXE_CAP);
        chk("irq", 32'h0, {31'h0, irq});
        i_btns_bus_model.cycle(16'hf000, 8'hc3, 1'b1, 1'b0, 6'h01);
        st_chk(`BTNS_ST_EXE_DUMP);
        chk("irq", 32'h1, {31'h0, irq});
        rc("counter", `BTNS_OFS_STATUS, 32'h3, 32'h1fff);
    endtask : t_exec

    task automatic t_dump;
        logic [31:0] q;
        wb(1'b0, `BTNS_OFS_DOWN, 32'h0, q);
        rc("data", `BTNS_OFS_DATA, 32'hc3);
        rc("addr lo", `BTNS_OFS_ADDR_LO, 32'h00);
        rc("addr hi", `BTNS_OFS_ADDR_HI, 32'hf0);
        rc("aux", `BTNS_OFS_AUX, 32'h81);
        wb(1'b0, `BTNS_OFS_DOWN, 32'h0, q);
        rc("data", `BTNS_OFS_DATA, 32'h3c);
        rc("aux", `BTNS_OFS_AUX, 32'haa);
        wb(1'b0, `BTNS_OFS_UP, 32'h0, q);
    endtask : t_dump

    task automatic t_nibble;
        wr(`BTNS_OFS_NIB_MODE, {24'h0, `BTNS_NIB_KEY});
        rc("shift status", `BTNS_OFS_SHIFT, 32'hdf);
        wr(`BTNS_OFS_SHIFT, 32'h0b);
        rc("shift c0", `BTNS_OFS_SHIFT, 32'h2);
        wr(`BTNS_OFS_SHIFT, 32'h5);
        rc("shift c1", `BTNS_OFS_SHIFT, 32'h0);
        wr(`BTNS_OFS_SHIFT, 32'ha);
        rc("shift c2", `BTNS_OFS_SHIFT, 32'h0);
        wr(`BTNS_OFS_SHIFT, 32'h3);
        rc("shift c3", `BTNS_OFS_SHIFT, 32'h0);
        wr(`BTNS_OFS_SHIFT, 32'h81);
        wr(`BTNS_OFS_NIB_MODE, {24'h0, `BTNS_NIB_KEY});
        rc("loaded", `BTNS_OFS_STATUS, 32'h200b_13a5, 32'h321f_1fff);
        rc("shift off", `BTNS_OFS_SHIFT, 32'h0);
        wr(`BTNS_OFS_PT_CLEAR, 32'hff);
        rc("pt count", `BTNS_OFS_PT_PRESET, 32'h0);
        // low byte lane off: the write is acked but must not land
        wb_sel_i <= 4'he;
        wr(`BTNS_OFS_PT_PRESET, 32'h0123);
        wb_sel_i <= 4'hf;
        rc("pt masked", `BTNS_OFS_PT_PRESET, 32'h0);
    endtask : t_nibble

    task automatic t_modes;
        logic [4:0]  st [3] = '{`BTNS_ST_RD_WAIT, `BTNS_ST_WR_WAIT, `BTNS_ST_AC_WAIT};
        logic [15:0] nca [3] = '{16'h0100, 16'h0100, 16'h0200};
        logic [2:0]  ncr = 3'b110;
        logic [2:0]  cr = 3'b101;
        for (int i = 0; i < 3; i++) begin
            wr(`BTNS_OFS_PT_PRESET, 32'd8191);
            wr(`BTNS_OFS_STATE, {27'h0, st[i]});
            i_btns_bus_model.cycle(16'he000, 8'h11, 1'b1, 1'b1, 6'h00);
            st_chk(st[i] + 5'h1);
            i_btns_bus_model.cycle(nca[i], 8'h22, ncr[i], 1'b0, 6'h00);
            st_chk(st[i] + 5'h1);
            i_btns_bus_model.cycle(16'h0100, 8'h33, cr[i], 1'b0, 6'h00);
            st_chk(st[i] + 5'h2);
            chk("irq", 32'h1, {31'h0, irq});
        end
    endtask : t_modes

    task automatic t_after;
        wr(`BTNS_OFS_PT_PRESET, 32'd8190);
        wr(`BTNS_OFS_STATE, {27'h0, `BTNS_ST_AFT_WAIT});
        i_btns_bus_model.cycle(16'hf000, 8'h44, 1'b1, 1'b1, 6'h00);
        st_chk(`BTNS_ST_AFT_CAP);
        chk("irq", 32'h0, {31'h0, irq});
        i_btns_bus_model.cycle(16'h0200, 8'h55, 1'b0, 1'b0, 6'h00);
        chk("irq", 32'h1, {31'h0, irq});
    endtask : t_after

    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        results();
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'hf;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_exec();
        t_dump();
        t_nibble();
        t_modes();
        t_after();
        results();
    end
endmodule : test_btns_sequencer

// ---- core/btns_capture_ram.sv ----
// one-write, one-async-read memory used for the capture buffer and the trigger table
// assumes writer and reader share clk_i; contents are not reset
`timescale 1ns/1ps
module btns_capture_ram #(
    parameter int W  = 33,
    parameter int AW = 13
) (
    input  logic          clk_i,
    input  logic          wr_en_i,
    input  logic [AW-1:0] wr_addr_i,
    input  logic [W-1:0]  wr_data_i,
    input  logic [AW-1:0] rd_addr_i,
    output logic [W-1:0]  rd_data_o
);
    logic [W-1:0] mem [0:(2**AW)-1];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[rd_addr_i];
endmodule : btns_capture_ram

// ---- core/btns_sequencer.sv ----
// trace sequencer: wishbone register slave, state machine, capture buffer and trigger table
// assumes bus_* inputs synchronous to clk_i; one traced bus cycle per rising edge of bus_e_i
`timescale 1ns/1ps
`include "btns_regs.svh"
module btns_sequencer #(
    parameter int          AW                = 13,
    parameter int unsigned INIT_CLEAR_CYCLES = `BTNS_INIT_CLEAR_CYCLES
) (
    input  logic        clk_i,
    input  logic        rst_i,
    input  logic [15:0] bus_addr_i,
    input  logic [7:0]  bus_data_i,
    input  logic        bus_read_i,
    input  logic        opcode_fetch_cycle_i,
    input  logic        bus_e_i,
    input  logic [5:0]  test_point_i,
    input  logic        wb_cyc_i,
    input  logic        wb_stb_i,
    input  logic        wb_we_i,
    input  logic [7:0]  wb_adr_i,
    input  logic [3:0]  wb_sel_i,
    input  logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic        wb_ack_o,
    output logic        nonmaskable_monitor_irq_o
);
    localparam int ICW = $clog2(INIT_CLEAR_CYCLES + 1);

    if (AW != 13 || INIT_CLEAR_CYCLES < 1) begin : g_bad_param
        $error("btns_sequencer: nibble exchange needs AW of 13 and a nonzero clear time");
    end

    logic [4:0]    state_r;
    logic [4:0]    state_nxt;
    logic [AW-1:0] capture_address_counter_r;
    logic [13:0]   pt_r;
    logic          e_q_r;
    logic          ack_r;
    logic [31:0]   dat_r;
    logic          irq_r, nib_r, trig_q_r, pulse_r;
    logic          en_t_r, en_a_r, init_done_r;
    logic [ICW-1:0] init_cnt_r;
    btns_pkg::btns_shift_type step_r;
    btns_pkg::btns_entry_type cur_entry;
    btns_pkg::btns_entry_type sel_entry;
    logic          trig, trig_hit, cap_wr, cap_mark, pt_pulse;
    logic [31:0]   rd_mux;

    // bus cycle qualifier: first clock of each E-high phase
    logic bus_cycle, top_hi, top_lo, fetch;
    assign bus_cycle = bus_e_i & ~e_q_r;
    assign top_hi    = bus_addr_i[15] & bus_addr_i[14];
    assign top_lo    = ~bus_addr_i[15] & ~bus_addr_i[14];
    assign fetch     = opcode_fetch_cycle_i;

    logic post_trigger_full_flag, post_trigger_half_flag;
    assign post_trigger_full_flag = pt_r[`BTNS_PT_FULL_BIT];
    assign post_trigger_half_flag = pt_r[`BTNS_PT_HALF_BIT];

    // wishbone strobes; side effects happen once, at the edge that raises ack
    logic acc, wr, rd;
    assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr  = acc & wb_we_i & wb_sel_i[0];
    assign rd  = acc & ~wb_we_i;

    logic in_dump;
    assign in_dump = (state_r == `BTNS_ST_EXE_DUMP) || (state_r == `BTNS_ST_RD_DUMP) ||
                     (state_r == `BTNS_ST_WR_DUMP) || (state_r == `BTNS_ST_AC_DUMP);

    logic sh_sel, sh_rd_ok, sh_wr_ok;
    assign sh_sel   = nib_r && (wb_adr_i == `BTNS_OFS_SHIFT);
    assign sh_rd_ok = sh_sel && rd && !step_r[0] && (step_r != btns_pkg::SH_DONE);
    assign sh_wr_ok = sh_sel && wr && step_r[0];

    // entry sampled as one word so all fields share the cycle
    assign cur_entry.mark = cap_mark;
    assign cur_entry.aux  = {bus_read_i, fetch, test_point_i};
    assign cur_entry.addr = bus_addr_i;
    assign cur_entry.data = bus_data_i;

    btns_capture_ram #(
        .W  (33),
        .AW (AW)
    ) u_capture (
        .clk_i     (clk_i),
        .wr_en_i   (cap_wr),
        .wr_addr_i (capture_address_counter_r),
        .wr_data_i (cur_entry),
        .rd_addr_i (capture_address_counter_r),
        .rd_data_o (sel_entry)
    );

    // top two address bits unconnected, so the table mirrors every 16K
    btns_capture_ram #(
        .W  (1),
        .AW (14)
    ) u_trigger_lookup_ram (
        .clk_i     (clk_i),
        .wr_en_i   (wr && (wb_adr_i == `BTNS_OFS_TRIG_LOAD)),
        .wr_addr_i (wb_dat_i[`BTNS_TRIG_IDX_LSB+13:`BTNS_TRIG_IDX_LSB]),
        .wr_data_i (wb_dat_i[0]),
        .rd_addr_i (bus_addr_i[13:0]),
        .rd_data_o (trig)
    );

    always_comb begin
        case (state_r)
            `BTNS_ST_EXE_CAP: trig_hit = top_hi & trig & bus_read_i;
            `BTNS_ST_RD_CAP:  trig_hit = top_lo & trig & bus_read_i;
            `BTNS_ST_WR_CAP:  trig_hit = top_lo & trig & ~bus_read_i;
            `BTNS_ST_AC_CAP:  trig_hit = top_lo & trig;
            default:          trig_hit = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        cap_wr    = 1'b0;
        cap_mark  = 1'b0;
        pt_pulse  = 1'b0;
        case (state_r)
            `BTNS_ST_INIT: cap_wr = bus_cycle;
            `BTNS_ST_AFT_WAIT: begin
                if (bus_cycle && top_hi && trig && fetch) begin
                    cap_wr    = 1'b1;
                    cap_mark  = 1'b1;
                    pt_pulse  = 1'b1;
                    state_nxt = `BTNS_ST_AFT_CAP;
                end
            end
            `BTNS_ST_AFT_CAP: begin
                if (!post_trigger_full_flag && bus_cycle) begin
                    cap_wr   = 1'b1;
                    cap_mark = fetch;
                    pt_pulse = 1'b1;
                end
            end
            `BTNS_ST_EXE_WAIT, `BTNS_ST_RD_WAIT, `BTNS_ST_WR_WAIT, `BTNS_ST_AC_WAIT: begin
                if (bus_cycle && top_hi && bus_read_i && fetch) begin
                    cap_wr    = 1'b1;
                    cap_mark  = 1'b1;
                    state_nxt = state_r + 5'h01;
                end
            end
            `BTNS_ST_EXE_CAP, `BTNS_ST_RD_CAP, `BTNS_ST_WR_CAP, `BTNS_ST_AC_CAP: begin
                if (post_trigger_full_flag) begin
                    state_nxt = state_r + 5'h01;
                end else if (bus_cycle) begin
                    cap_wr   = 1'b1;
                    cap_mark = fetch;
                    pt_pulse = trig_hit;
                end
            end
            default: state_nxt = state_r;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= `BTNS_ST_INIT;
        end else if (wr && (wb_adr_i == `BTNS_OFS_STATE)) begin
            state_r <= wb_dat_i[4:0];
        end else if (sh_wr_ok && step_r == btns_pkg::SH_STATE_WR) begin
            state_r <= {state_r[4], wb_dat_i[3:0]};
        end else begin
            state_r <= state_nxt;
        end
    end

    // software stepping and nibble loads win over capture advance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_address_counter_r <= '0;
        end else if (sh_wr_ok) begin
            case (step_r)
                btns_pkg::SH_C0_WR: capture_address_counter_r[3:0]  <= wb_dat_i[3:0];
                btns_pkg::SH_C1_WR: capture_address_counter_r[7:4]  <= wb_dat_i[3:0];
                btns_pkg::SH_C2_WR: capture_address_counter_r[11:8] <= wb_dat_i[3:0];
                btns_pkg::SH_C3_WR: capture_address_counter_r[12]   <= wb_dat_i[0];
                default: capture_address_counter_r <= capture_address_counter_r;
            endcase
        end else if (rd && wb_adr_i == `BTNS_OFS_DOWN) begin
            capture_address_counter_r <= capture_address_counter_r - 1'b1;
        end else if (rd && wb_adr_i == `BTNS_OFS_UP) begin
            capture_address_counter_r <= capture_address_counter_r + 1'b1;
        end else if (cap_wr) begin
            capture_address_counter_r <= capture_address_counter_r + 1'b1;
        end
    end

    // counter saturates at full; a pulse in the clear cycle still counts
    logic pt_step;
    assign pt_step = pt_pulse & ~post_trigger_full_flag;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pt_r <= '0;
        end else if (wr && wb_adr_i == `BTNS_OFS_PT_CLEAR) begin
            pt_r <= {13'h0000, pt_step};
        end else if (wr && wb_adr_i == `BTNS_OFS_PT_PRESET) begin
            pt_r <= {1'b0, wb_dat_i[12:0]};
        end else if (pt_step) begin
            pt_r <= pt_r + 14'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nib_r  <= 1'b0;
            step_r <= btns_pkg::SH_STATUS_RD;
        end else if (wr && wb_adr_i == `BTNS_OFS_NIB_MODE && wb_dat_i[7:0] == `BTNS_NIB_KEY) begin
            nib_r  <= ~nib_r;
            step_r <= btns_pkg::SH_STATUS_RD;
        end else if (sh_rd_ok || sh_wr_ok) begin
            step_r <= btns_pkg::btns_shift_type'(step_r + 4'h1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_t_r <= 1'b0;
            en_a_r <= 1'b0;
        end else if (sh_wr_ok && step_r == btns_pkg::SH_C3_WR) begin
            en_t_r <= wb_dat_i[7];
            en_a_r <= wb_dat_i[6];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            e_q_r    <= 1'b0;
            trig_q_r <= 1'b0;
            pulse_r  <= 1'b0;
        end else begin
            e_q_r <= bus_e_i;
            if (bus_cycle) begin
                trig_q_r <= trig;
                pulse_r  <= pt_step;
            end
        end
    end

    // time spent in init; long enough means every mark has been zeroed
    always_ff @(posedge clk_i) begin
        if (rst_i || state_r != `BTNS_ST_INIT) begin
            init_cnt_r  <= '0;
            init_done_r <= 1'b0;
        end else if (init_cnt_r == ICW'(INIT_CLEAR_CYCLES)) begin
            init_done_r <= 1'b1;
        end else begin
            init_cnt_r <= init_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= in_dump || (state_r == `BTNS_ST_AFT_CAP && post_trigger_full_flag);
        end
    end

    // buffer bytes read as zero outside the dump states
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (wb_adr_i == `BTNS_OFS_DATA) begin
            rd_mux[7:0] = in_dump ? sel_entry.data : 8'h00;
        end else if (wb_adr_i == `BTNS_OFS_ADDR_LO) begin
            rd_mux[7:0] = in_dump ? sel_entry.addr[7:0] : 8'h00;
        end else if (wb_adr_i == `BTNS_OFS_ADDR_HI) begin
            rd_mux[7:0] = in_dump ? sel_entry.addr[15:8] : 8'h00;
        end else if (wb_adr_i == `BTNS_OFS_AUX) begin
            rd_mux[7:0] = in_dump ? sel_entry.aux : 8'h00;
        end else if (sh_sel) begin
            case (step_r)
                btns_pkg::SH_STATUS_RD: rd_mux[7:0] = {trig_q_r, post_trigger_full_flag,
                                                       post_trigger_half_flag, pulse_r, state_r[3:0]};
                btns_pkg::SH_C0_RD: rd_mux[3:0] = capture_address_counter_r[3:0];
                btns_pkg::SH_C1_RD: rd_mux[3:0] = capture_address_counter_r[7:4];
                btns_pkg::SH_C2_RD: rd_mux[3:0] = capture_address_counter_r[11:8];
                btns_pkg::SH_C3_RD: rd_mux[0]   = capture_address_counter_r[12];
                default:            rd_mux      = 32'h0000_0000;
            endcase
        end else if (wb_adr_i == `BTNS_OFS_STATE) begin
            rd_mux[4:0] = state_r;
        end else if (wb_adr_i == `BTNS_OFS_PT_PRESET) begin
            rd_mux[13:0] = pt_r;
        end else if (wb_adr_i == `BTNS_OFS_STATUS) begin
            rd_mux = {2'b00, en_t_r, en_a_r, init_done_r, sel_entry.mark, nib_r, pulse_r,
                      trig_q_r, post_trigger_half_flag, post_trigger_full_flag, state_r,
                      3'b000, capture_address_counter_r};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            if (acc) begin
                dat_r <= wb_we_i ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign wb_ack_o                  = ack_r;
    assign wb_dat_o                  = dat_r;
    assign nonmaskable_monitor_irq_o = irq_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wait_start_a: assert property ((state_r == `BTNS_ST_EXE_WAIT) && bus_cycle && top_hi && bus_read_i && fetch
        && !acc |=> state_r == `BTNS_ST_EXE_CAP && capture_address_counter_r == $past(capture_address_counter_r) + 1'b1)
        else $error("fetch in wait state did not start capture");
    cap_advance_a: assert property ((state_r == `BTNS_ST_RD_CAP) && !post_trigger_full_flag && bus_cycle && !acc
        |=> capture_address_counter_r == $past(capture_address_counter_r) + 1'b1)
        else $error("capture cycle did not advance counter");
    exe_pulse_a: assert property ((state_r == `BTNS_ST_EXE_CAP) && bus_cycle && top_hi && trig && bus_read_i
        && !post_trigger_full_flag && !acc |=> pt_r == $past(pt_r) + 14'h0001)
        else $error("execution trigger did not pulse counter");
    exe_dump_a: assert property ((state_r == `BTNS_ST_EXE_CAP) && post_trigger_full_flag && !acc
        |=> state_r == `BTNS_ST_EXE_DUMP ##1 nonmaskable_monitor_irq_o)
        else $error("full flag did not lead to dump and interrupt");
    after_irq_a: assert property ((state_r == `BTNS_ST_AFT_CAP) && post_trigger_full_flag && !acc
        |=> nonmaskable_monitor_irq_o)
        else $error("trace-after did not interrupt when buffer filled");
    down_read_a: assert property (rd && wb_adr_i == `BTNS_OFS_DOWN && !sh_wr_ok
        |=> capture_address_counter_r == $past(capture_address_counter_r) - 1'b1 && wb_ack_o)
        else $error("down read did not decrement counter");
    pt_clear_a: assert property (wr && wb_adr_i == `BTNS_OFS_PT_CLEAR && !pt_step |=> pt_r == 14'h0000)
        else $error("post-trigger clear did not zero counter");
    nib_toggle_a: assert property (wr && wb_adr_i == `BTNS_OFS_NIB_MODE && wb_dat_i[7:0] == `BTNS_NIB_KEY
        |=> nib_r != $past(nib_r) && step_r == btns_pkg::SH_STATUS_RD)
        else $error("nibble mode did not toggle");
    write_mode_a: assert property ((state_r == `BTNS_ST_WR_CAP) && bus_cycle && top_lo && trig && bus_read_i
        && !acc |=> pt_r == $past(pt_r))
        else $error("read counted in write mode");
    dump_data_a: assert property (rd && wb_adr_i == `BTNS_OFS_DATA && in_dump
        |=> wb_ack_o && wb_dat_o == {24'h000000, $past(sel_entry.data)})
        else $error("dump data read returned wrong byte");

    exe_trip_c: cover property (state_r == `BTNS_ST_EXE_CAP ##1 state_r == `BTNS_ST_EXE_DUMP);
    acc_trip_c: cover property (state_r == `BTNS_ST_AC_CAP ##1 state_r == `BTNS_ST_AC_DUMP);
    nib_done_c: cover property (nib_r && step_r == btns_pkg::SH_DONE);
    init_done_c: cover property (init_done_r);
endmodule : btns_sequencer

// ---- shared/btns_pkg.sv ----
// types shared by the trace sequencer files
// assumes btns_regs.svh carries all numeric constants
package btns_pkg;

    typedef struct packed {
        logic       mark;
        logic [7:0] aux;
        logic [15:0] addr;
        logic [7:0] data;
    } btns_entry_type;

    typedef enum logic [3:0] {
        SH_STATUS_RD,
        SH_STATE_WR,
        SH_C0_RD,
        SH_C0_WR,
        SH_C1_RD,
        SH_C1_WR,
        SH_C2_RD,
        SH_C2_WR,
        SH_C3_RD,
        SH_C3_WR,
        SH_DONE
    } btns_shift_type;

endpackage : btns_pkg

// ---- shared/btns_regs.svh ----
// register offsets, field values, state codes and timing counts of the trace sequencer
// assumes a 32-bit wishbone slave with an 8-bit byte address
`ifndef BTNS_REGS_SVH
`define BTNS_REGS_SVH

`define BTNS_OFS_DATA      8'h00
`define BTNS_OFS_ADDR_LO   8'h04
`define BTNS_OFS_ADDR_HI   8'h08
`define BTNS_OFS_AUX       8'h0c
`define BTNS_OFS_DOWN      8'h10
`define BTNS_OFS_UP        8'h14
`define BTNS_OFS_PT_CLEAR  8'h18
`define BTNS_OFS_NIB_MODE  8'h1c
`define BTNS_OFS_SHIFT     8'h20
`define BTNS_OFS_STATE     8'h24
`define BTNS_OFS_PT_PRESET 8'h28
`define BTNS_OFS_STATUS    8'h2c
`define BTNS_OFS_TRIG_LOAD 8'h30

`define BTNS_NIB_KEY       8'h80
`define BTNS_PT_FULL_BIT   13
`define BTNS_PT_HALF_BIT   12
`define BTNS_TRIG_IDX_LSB  16

`define BTNS_ST_INIT       5'h05
`define BTNS_ST_AFT_WAIT   5'h0b
`define BTNS_ST_AFT_CAP    5'h0c
`define BTNS_ST_EXE_WAIT   5'h0d
`define BTNS_ST_EXE_CAP    5'h0e
`define BTNS_ST_EXE_DUMP   5'h0f
`define BTNS_ST_RD_WAIT    5'h10
`define BTNS_ST_RD_CAP     5'h11
`define BTNS_ST_RD_DUMP    5'h12
`define BTNS_ST_WR_WAIT    5'h14
`define BTNS_ST_WR_CAP     5'h15
`define BTNS_ST_WR_DUMP    5'h16
`define BTNS_ST_AC_WAIT    5'h18
`define BTNS_ST_AC_CAP     5'h19
`define BTNS_ST_AC_DUMP    5'h1a

`define BTNS_CLK_PERIOD_NS   4
`define BTNS_INIT_CLEAR_NS   4100000
`define BTNS_INIT_CLEAR_CYCLES ((`BTNS_INIT_CLEAR_NS + `BTNS_CLK_PERIOD_NS - 1) / `BTNS_CLK_PERIOD_NS)

`endif
